// ---- tb/gctl_monitor.sv ----
// Port-level checker for the global control bank.
`timescale 1ns/1ns
module gctl_monitor
  import gctl_pkg::*;
#(
  parameter int ports = 4
)
(
  input wire logic                   clk_sys,
  input wire logic                   rst_b,
  input wire gctl_pkg::host_req_t    host_req,
  input wire logic [7:0]             host_rdata,
  input wire logic [ports-1:0]       port_wr,
  input wire logic [ports-1:0]       rx_loss_of_frame,
  input wire logic [ports-1:0]       tx_clock_loss,
  input wire logic [ports-1:0]       framer_loss,
  input wire logic [ports-1:0]       liu_loss,
  input wire logic [ports-1:0]       rx_sig_freeze,
  input wire logic [ports-1:0]       counter_latch_accept,
  input wire logic                   tx_system_sync_pin_in,
  input wire logic                   tx_system_sync_pin_oe,
  input wire logic                   frame_pulse_8k,
  input wire logic                   tx_sync_to_framers,
  input wire gctl_pkg::port_pins_t   pins,
  input wire gctl_pkg::clock_cfg_t   clock_cfg,
  input wire logic [1:0]             interleave_mode_field,
  input wire logic                   interleave_wire_or_select,
  input wire logic [ports-1:0]       counter_latch_pulse,
  input wire logic                   interrupt_out_n
);
  logic [7:0] sh [0:3]; // Shadow of the four control registers at 0x0f0 to 0x0f3.
  wire        pw = host_req.wr && host_req.addr[11:10] == 2'h0 && host_req.addr[7:0] < 8'hf0; // Port write.

  // Shadow follows host writes so the steering outputs can be predicted.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      sh <= '{default: 8'h00};
    else if (host_req.wr && host_req.addr[11:2] == 10'h03c)
      sh[host_req.addr[1:0]] <= host_req.wdata;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  frame_alarm_a: assert property (pins.frame_alarm_pin == (sh[0][5] ? tx_clock_loss : rx_loss_of_frame))
    else $error("frame alarm pins wrong");
  wire_or_a: assert property (interleave_wire_or_select == sh[0][4])
    else $error("wire-or select wrong");
  port_fanout_a: assert property (1'b1 |=> port_wr ==
    (!$past(pw) ? 4'h0 : sh[0][2] ? 4'hf : 4'h1 << $past(host_req.addr[9:8])))
    else $error("port write fan-out wrong");
  latch_rise_a: assert property ($rose(sh[0][1]) |=> counter_latch_pulse == counter_latch_accept)
    else $error("counter latch pulse missing");
  latch_quiet_a: assert property (!$rose(sh[0][1]) |=> counter_latch_pulse == 4'h0)
    else $error("counter latch pulse without rising edge");
  irq_inhibit_a: assert property (sh[0][0] && $past(sh[0][0]) |-> interrupt_out_n)
    else $error("interrupt output not inhibited");
  bus_mode_a: assert property (interleave_mode_field == sh[1][7:6] &&
    clock_cfg.backplane_mult == 5'h1 << sh[1][5:4])
    else $error("interleave or backplane selection wrong");
  alarm_pins_a: assert property (pins.alarm_pin ==
    (sh[1][3] ? rx_sig_freeze : sh[2][2] ? liu_loss : framer_loss))
    else $error("alarm pins wrong");
  sync_pin_a: assert property (tx_system_sync_pin_oe == sh[2][1] &&
    tx_sync_to_framers == (sh[2][1] ? frame_pulse_8k : tx_system_sync_pin_in))
    else $error("sync pin direction wrong");
  master_clock_a: assert property (clock_cfg.master_family == sh[3][2] &&
    clock_cfg.master_multiplier == 4'h1 << sh[3][1:0])
    else $error("master clock decode wrong");
  ref_decode_a: assert property (clock_cfg.ref_is_1m544 == sh[3][3] &&
    clock_cfg.ref_pin_oe == (sh[3][7:4] inside {4'h8, 4'h9}) && clock_cfg.ref_external == (sh[3][7:4] == 4'ha) &&
    clock_cfg.ref_port_onehot == (sh[3][7:6] == 2'h0 ? 4'h1 << sh[3][5:4] : 4'h0))
    else $error("reference select decode wrong");
  ident_read_a: assert property (host_req.rd && host_req.addr == off_identification |=> host_rdata == ident_default)
    else $error("identification read wrong");

  bulk_c: cover property (pw && sh[0][2]);
  latch_c: cover property (counter_latch_pulse != 4'h0);
  irq_c: cover property (!interrupt_out_n);
  refpin_c: cover property (clock_cfg.ref_pin_oe);
endmodule // gctl_monitor

// ---- tb/tb_top.sv ----
// Directed register-level testbench for the global control bank.
`timescale 1ns/1ns
module tb_top;
  import gctl_pkg::*;
  logic         clk_sys = 1'b0;                  // 25 MHz system clock.
  logic         rst_b = 1'b0;                    // Synchronous reset, active low.
  host_req_t    host_req = '0;                   // Register bus request.
  logic [43:0]  stat = 44'h1e2d3c4b5a6;          // Per-port status levels, flipped between steps.
  logic [3:0]   framer_irq = 4'h0;               // Framer interrupt levels.
  logic         frame_pulse_8k = 1'b0;           // Internal frame pulse stand-in.
  logic         sync_in = 1'b1;                  // Level on the sync pin from outside.
  logic [7:0]   host_rdata, port_wr_offset, port_wr_data;
  logic [3:0]   port_wr, counter_latch_pulse, liu_soft_reset, framer_soft_reset;
  logic         sync_out, sync_oe, sync_framers, wire_or, interrupt_out_n;
  port_pins_t   pins;
  clock_cfg_t   clock_cfg;
  interleave_mode_t mode;
  int           num_errors = 0, n_tests = 0, hits;
  logic [11:0]  offs [10] = '{12'h0f0, 12'h0f1, 12'h0f2, 12'h0f3, 12'h0f4, 12'h0f5, 12'h0f6, 12'h0fc, 12'h0fe, 12'h0ff};
  logic [7:0]   fp [8] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h08, 8'h0c, 8'h13, 8'he4};
  logic [7:0]   cc [8] = '{8'h00, 8'h17, 8'h26, 8'h3b, 8'h89, 8'h90, 8'ha4, 8'had};

  always #20 clk_sys = ~clk_sys;
  // The pulse and the pin level move every cycle so both mux inputs are seen.
  always @(posedge clk_sys) {frame_pulse_8k, sync_in} <= {~frame_pulse_8k, frame_pulse_8k};

  quad_transceiver_global_control quad_transceiver_global_control_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .host_req(host_req), .host_rdata(host_rdata),
    .port_wr(port_wr), .port_wr_offset(port_wr_offset), .port_wr_data(port_wr_data),
    .rx_loss_of_frame(stat[3:0]), .tx_clock_loss(stat[7:4]), .framer_loss(stat[11:8]),
    .liu_loss(stat[15:12]), .rx_sig_freeze(stat[19:16]), .rx_frame_sync(stat[23:20]),
    .rx_multiframe_sync(stat[27:24]), .tx_channel_block(stat[31:28]), .tx_channel_clock(stat[35:32]),
    .rx_channel_block(stat[39:36]), .rx_channel_clock(stat[43:40]), .framer_irq(framer_irq),
    .tester_irq(4'h6), .liu_irq(4'h0), .counter_latch_accept(4'h9), .tx_system_sync_pin_in(sync_in),
    .tx_system_sync_pin_out(sync_out), .tx_system_sync_pin_oe(sync_oe), .frame_pulse_8k(frame_pulse_8k),
    .tx_sync_to_framers(sync_framers), .pins(pins), .clock_cfg(clock_cfg), .interleave_mode_field(mode),
    .interleave_wire_or_select(wire_or), .counter_latch_pulse(counter_latch_pulse),
    .liu_soft_reset(liu_soft_reset), .framer_soft_reset(framer_soft_reset), .interrupt_out_n(interrupt_out_n));

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle host write; returns just after the edge that took it.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    host_req.wr <= 1'b0;
    #1;
  endtask
  // One-cycle host read; the data stand only in the following cycle.
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    host_req.rd <= 1'b0;
    #1;
    check(host_rdata, exp);
  endtask
  // Writes control one and counts latch pulses in the cycles after.
  task automatic latch_step(input logic [7:0] d, input int n);
    wr(off_control_one, d);
    hits = 0;
    repeat (4)
    begin
      @(posedge clk_sys);
      #1;
      if (counter_latch_pulse !== 4'h0)
      begin
        hits++;
        check(counter_latch_pulse, 4'h9);
      end
    end
    check(hits, n);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence of directed tests.
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(off_reserved_a, 8'h00);
    wr(off_reserved_b, 8'h00);
    foreach (offs[i]) rd(offs[i], 8'h00);
    rd(off_identification, ident_default);
    wr(off_identification, 8'h5a);
    wr(off_tester_summary, 8'hff);
    rd(off_identification, ident_default);
    rd(off_tester_summary, 8'h06);
    $display("test reset_and_readonly done");
    check(interrupt_out_n, 1'b0);
    wr(off_control_one, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    check(interrupt_out_n, 1'b1);
    wr(off_control_one, 8'h00);
    wr(off_tester_mask, 8'hff);
    rd(off_tester_mask, 8'h0f);
    framer_irq <= 4'h2;
    wr(off_framer_mask, 8'h0f);
    repeat (2) @(posedge clk_sys);
    #1;
    check(interrupt_out_n, 1'b1);
    wr(off_framer_mask, 8'h0d);
    repeat (2) @(posedge clk_sys);
    #1;
    check(interrupt_out_n, 1'b0);
    $display("test interrupt done");
    for (int i = 0; i < 8; i++)
    begin
      wr(off_framer_pin, fp[i]);
      wr(off_clock_control, cc[i]);
      wr(off_control_two, {5'h00, i[0], i[1], 1'b0});
      wr(off_control_one, {2'h0, i[0], i[1], 4'h0});
      check(mode, fp[i][7:6]);
      check(pins.rx_sync_pin, fp[i][2] ? stat[27:24] : stat[23:20]);
      check(pins.tx_channel_pin, fp[i][1] ? stat[35:32] : stat[31:28]);
      check(pins.rx_channel_pin, fp[i][0] ? stat[43:40] : stat[39:36]);
      check(clock_cfg.master_multiplier, 4'h1 << cc[i][1:0]);
      check(sync_oe, i[1]);
      check(sync_out, frame_pulse_8k);
      stat <= ~stat;
      rd(off_clock_control, cc[i]);
    end
    $display("test pin_and_clock_select done");
    wr(12'h123, 8'h55);
    check({port_wr, port_wr_offset, port_wr_data}, 20'h22355);
    wr(12'h1f0, 8'h00);
    check(port_wr, 4'h0);
    rd(off_control_one, 8'h30);
    wr(off_control_one, 8'h04);
    wr(12'h345, 8'haa);
    check({port_wr, port_wr_offset, port_wr_data}, 20'hf45aa);
    wr(off_control_one, 8'h00);
    rd(off_control_one, 8'h00);
    $display("test port_write done");
    latch_step(8'h02, 1);
    latch_step(8'h03, 0);
    latch_step(8'h01, 0);
    latch_step(8'h02, 1);
    wr(off_liu_reset, 8'hff);
    check(liu_soft_reset, 4'hf);
    rd(off_liu_reset, 8'h0f);
    wr(off_framer_reset, 8'h0a);
    check(framer_soft_reset, 4'ha);
    $display("test latch_and_soft_reset done");
    stop_test();
  end

  // Cuts a hung run short.
  initial
  begin
    #200000;
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // tb_top

bind quad_transceiver_global_control gctl_monitor #(.ports(ports)) gctl_monitor_inst (.*);

// ---- verilog/gctl_pkg.sv ----
// Package of offsets, field positions, encodings and carriers for the global control bank.
package gctl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] off_control_one      = 12'h0f0; // Transceiver control one.
  localparam logic [11:0] off_framer_pin       = 12'h0f1; // Framer pin control.
  localparam logic [11:0] off_control_two      = 12'h0f2; // Transceiver control two.
  localparam logic [11:0] off_clock_control    = 12'h0f3; // Clock control.
  localparam logic [11:0] off_reserved_a       = 12'h0f4; // Reserved location.
  localparam logic [11:0] off_liu_reset        = 12'h0f5; // Line interface soft reset.
  localparam logic [11:0] off_framer_reset     = 12'h0f6; // Framer and tester soft reset.
  localparam logic [11:0] off_reserved_b       = 12'h0f7; // Reserved location.
  localparam logic [11:0] off_identification   = 12'h0f8; // Identification.
  localparam logic [11:0] off_framer_summary   = 12'h0f9; // Framer interrupt summary.
  localparam logic [11:0] off_tester_summary   = 12'h0fa; // Tester interrupt summary.
  localparam logic [11:0] off_liu_summary      = 12'h0fb; // Line interface interrupt summary.
  localparam logic [11:0] off_framer_mask      = 12'h0fc; // Framer interrupt mask.
  localparam logic [11:0] off_tester_mask      = 12'h0fd; // Tester interrupt mask.
  localparam logic [11:0] off_liu_mask         = 12'h0fe; // Line interface interrupt mask.

  // Per-port register window: low 8 bits are the register, port above.
  localparam logic [11:0] port_window_mask     = 12'h0ff; // Offset inside one port.
  localparam logic [11:0] port_global_base     = 12'h0f0; // Start of the global range.

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int bit_frame_alarm_pin_select   = 5;
  localparam int bit_interleave_wire_or       = 4;
  localparam int bit_bulk_write_enable        = 2;
  localparam int bit_counter_latch_strobe     = 1;
  localparam int bit_interrupt_pin_inhibit    = 0;
  localparam int bit_loss_source              = 2;
  localparam int bit_sync_pin_direction       = 1;
  localparam logic [7:0] reg_reset_value      = 8'h00; // All defaults zero.
  localparam logic [3:0] port_field_mask      = 4'hf;  // Four-port fields in reset/mask regs.

  // Identification value; arbitrary neutral value.
  localparam logic [7:0] ident_default        = 8'ha5;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ib_disabled = 2'h0, ib_two = 2'h1, ib_four = 2'h2, ib_eight = 2'h3
  } interleave_mode_t;

  typedef enum logic [1:0] {
    bp_2m048 = 2'h0, bp_4m096 = 2'h1, bp_8m192 = 2'h2, bp_16m384 = 2'h3
  } backplane_freq_t;

  localparam logic [3:0] ref_port_last       = 4'h3; // Codes 0..3 pick a port.
  localparam logic [3:0] ref_master_1m544    = 4'h8;
  localparam logic [3:0] ref_master_2m048    = 4'h9;
  localparam logic [3:0] ref_external        = 4'ha;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // One register-bus request.
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } host_req_t;

  // Decoded clock configuration handed to the clock generator.
  typedef struct packed {
    logic [3:0]  ref_port_onehot;  // Recovered clock of port n chosen.
    logic        ref_from_master;  // Reference derived from master clock.
    logic        ref_external;     // Reference taken on the reference pin.
    logic        ref_pin_oe;       // Reference pin driven out.
    logic        ref_is_1m544;     // Reference frequency flag.
    logic        master_family;    // Master clock family.
    logic [3:0]  master_multiplier; // 1, 2, 4 or 8.
    logic [4:0]  backplane_mult;   // Backplane clock as multiple of 2.048.
  } clock_cfg_t;

  // Four-port pin selections.
  typedef struct packed {
    logic [3:0] frame_alarm_pin;
    logic [3:0] alarm_pin;
    logic [3:0] rx_sync_pin;
    logic [3:0] tx_channel_pin;
    logic [3:0] rx_channel_pin;
  } port_pins_t;

endpackage : gctl_pkg

// ---- verilog/quad_transceiver_global_control.sv ----
// Global control register bank and shared pin steering of the four-port transceiver.
//
// Functional notes
// - Bit 5 picks frame loss or tx clock.
// - Bit 4 picks internal mux or wire-OR.
// - Bulk write copies a port write to all four.
// - Rising counter-latch bit latches enabled counters.
// - Inhibit bit forces interrupt output high.
// - Interleave mode field selects mux size, rate.
// - Backplane field selects backplane clock frequency.
// - Alarm pins show receive loss or freeze.
// - Loss source picks line or framer detector.
// - Rx sync pins show frame or multiframe.
// - Tx channel pins show block or clock.
// - Rx channel pins show block or clock.
// - Sync direction bit drives 8kHz pulse out.
// - Reference field picks port, external, master clock.
// - Reference frequency bit matches chosen port standard.
// - Family bit sets master clock base frequency.
// - Period field multiplies base by 1,2,4,8.
// - Reference codes map ports, master derivations, external.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns

module quad_transceiver_global_control
  import gctl_pkg::*;
#(
  parameter int ports = 4
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // Host register port.
  input  wire gctl_pkg::host_req_t    host_req,
  output logic [7:0]                  host_rdata,
  // Per-port register write fan-out toward the framer, tester and line interface sets.
  output logic [ports-1:0]            port_wr,
  output logic [7:0]                  port_wr_offset,
  output logic [7:0]                  port_wr_data,
  // Per-port events and status from the framers, testers and line interfaces.
  input  wire logic [ports-1:0]       rx_loss_of_frame,
  input  wire logic [ports-1:0]       tx_clock_loss,
  input  wire logic [ports-1:0]       framer_loss,
  input  wire logic [ports-1:0]       liu_loss,
  input  wire logic [ports-1:0]       rx_sig_freeze,
  input  wire logic [ports-1:0]       rx_frame_sync,
  input  wire logic [ports-1:0]       rx_multiframe_sync,
  input  wire logic [ports-1:0]       tx_channel_block,
  input  wire logic [ports-1:0]       tx_channel_clock,
  input  wire logic [ports-1:0]       rx_channel_block,
  input  wire logic [ports-1:0]       rx_channel_clock,
  input  wire logic [ports-1:0]       framer_irq,
  input  wire logic [ports-1:0]       tester_irq,
  input  wire logic [ports-1:0]       liu_irq,
  input  wire logic [ports-1:0]       counter_latch_accept,
  // Transmit sync pin, internal 8kHz pulse and backplane control.
  input  wire logic                   tx_system_sync_pin_in,
  output logic                        tx_system_sync_pin_out,
  output logic                        tx_system_sync_pin_oe,
  input  wire logic                   frame_pulse_8k,
  output logic                        tx_sync_to_framers,
  // Shared pins and configuration outputs.
  output gctl_pkg::port_pins_t        pins,
  output gctl_pkg::clock_cfg_t        clock_cfg,
  output gctl_pkg::interleave_mode_t  interleave_mode_field,
  output logic                        interleave_wire_or_select,
  output logic [ports-1:0]            counter_latch_pulse,
  output logic [ports-1:0]            liu_soft_reset,
  output logic [ports-1:0]            framer_soft_reset,
  output logic                        interrupt_out_n
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // All state of the block in one record.
  typedef struct packed {
    logic [7:0]       control_one;     // Transceiver control one.
    logic [7:0]       framer_pin;      // Framer pin control.
    logic [7:0]       control_two;     // Transceiver control two.
    logic [7:0]       clock_control;   // Clock control.
    logic [ports-1:0] liu_reset;       // Line interface soft resets.
    logic [ports-1:0] framer_reset;    // Framer soft resets.
    logic [ports-1:0] framer_mask;     // Framer summary mask.
    logic [ports-1:0] tester_mask;     // Tester summary mask.
    logic [ports-1:0] liu_mask;        // Line interface summary mask.
    logic             latch_prev;      // Last counter-latch bit value.
    logic [ports-1:0] latch_pulse;     // Registered latch pulses.
    logic [ports-1:0] wr_pulse;        // Registered port write strobes.
    logic [7:0]       wr_offset;       // Registered port write offset.
    logic [7:0]       wr_data;         // Registered port write data.
    logic [7:0]       rdata;           // Read data, valid the cycle after a read.
    logic             irq_n;           // Registered interrupt output.
  } state_t;

  state_t cur;      // Current state.
  state_t next_st;  // Next state.

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Widens a four-port field to a register byte with zeros above.
  function automatic logic [7:0] widen(input logic [ports-1:0] v);
    widen = 8'(v);
  endfunction

  // Selects between two per-port sources by one control bit.
  function automatic logic [ports-1:0] pick(input logic sel,
                                            input logic [ports-1:0] a,
                                            input logic [ports-1:0] b);
    pick = sel ? b : a;
  endfunction

  logic [ports-1:0] port_of_addr;   // One-hot port targeted by the address.
  logic             is_global;      // Address offset in the global range, in any port window.
  logic             in_port_range;  // Address inside the four port windows.
  logic [1:0]       port_index;     // Port number of the address.

  // Decodes the address into port and global range.
  always_comb
  begin
    port_index    = host_req.addr[9:8];
    in_port_range = (host_req.addr[11:10] == 2'h0);
    port_of_addr  = '0;
    port_of_addr[port_index] = in_port_range;
    is_global     = ((host_req.addr & port_window_mask) >= port_global_base);
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Applies host writes, forms read data, latch pulses and the interrupt level.
  always_comb
  begin
    logic [ports-1:0] f_sum;
    logic [ports-1:0] t_sum;
    logic [ports-1:0] l_sum;
    logic             any_irq;
    logic             latch_now;
    any_irq   = 1'b0;
    latch_now = 1'b0;
    next_st = cur;
    f_sum   = framer_irq;
    t_sum   = tester_irq;
    l_sum   = liu_irq;
    next_st.wr_pulse    = '0;
    next_st.latch_pulse = '0;
    // Register writes; read-only and reserved locations ignore them.
    if (host_req.wr && host_req.addr == off_control_one)
      next_st.control_one = host_req.wdata;
    if (host_req.wr && host_req.addr == off_framer_pin)
      next_st.framer_pin = host_req.wdata;
    if (host_req.wr && host_req.addr == off_control_two)
      next_st.control_two = host_req.wdata;
    if (host_req.wr && host_req.addr == off_clock_control)
      next_st.clock_control = host_req.wdata;
    if (host_req.wr && host_req.addr == off_liu_reset)
      next_st.liu_reset = host_req.wdata[ports-1:0];
    if (host_req.wr && host_req.addr == off_framer_reset)
      next_st.framer_reset = host_req.wdata[ports-1:0];
    if (host_req.wr && host_req.addr == off_framer_mask)
      next_st.framer_mask = host_req.wdata[ports-1:0];
    if (host_req.wr && host_req.addr == off_tester_mask)
      next_st.tester_mask = host_req.wdata[ports-1:0];
    if (host_req.wr && host_req.addr == off_liu_mask)
      next_st.liu_mask = host_req.wdata[ports-1:0];
    // Port register writes fan out to one or, under bulk write, all ports.
    if (host_req.wr && in_port_range && !is_global)
    begin
      next_st.wr_pulse  = cur.control_one[bit_bulk_write_enable] ? '1 : port_of_addr;
      next_st.wr_offset = host_req.addr[7:0];
      next_st.wr_data   = host_req.wdata;
    end
    // Read multiplexer; identification and summaries are read-only.
    next_st.rdata = reg_reset_value;
    if (host_req.rd)
    begin
      unique case (host_req.addr)
        off_control_one:    next_st.rdata = cur.control_one;
        off_framer_pin:     next_st.rdata = cur.framer_pin;
        off_control_two:    next_st.rdata = cur.control_two;
        off_clock_control:  next_st.rdata = cur.clock_control;
        off_liu_reset:      next_st.rdata = widen(cur.liu_reset);
        off_framer_reset:   next_st.rdata = widen(cur.framer_reset);
        off_identification: next_st.rdata = ident_default;
        off_framer_summary: next_st.rdata = widen(f_sum);
        off_tester_summary: next_st.rdata = widen(t_sum);
        off_liu_summary:    next_st.rdata = widen(l_sum);
        off_framer_mask:    next_st.rdata = widen(cur.framer_mask);
        off_tester_mask:    next_st.rdata = widen(cur.tester_mask);
        off_liu_mask:       next_st.rdata = widen(cur.liu_mask);
        default:            next_st.rdata = reg_reset_value;
      endcase
    end
    // Rising edge of the latch bit makes one pulse per enabled framer.
    latch_now = cur.control_one[bit_counter_latch_strobe];
    next_st.latch_prev = latch_now;
    if (latch_now && !cur.latch_prev)
      next_st.latch_pulse = counter_latch_accept;
    // Interrupt output low on any unmasked summary unless inhibited.
    any_irq = |(f_sum & ~cur.framer_mask) | |(t_sum & ~cur.tester_mask) | |(l_sum & ~cur.liu_mask);
    next_st.irq_n = cur.control_one[bit_interrupt_pin_inhibit] ? 1'b1 : !any_irq;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Synchronous active-low reset returns every field to zero, output high.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cur       <= '0;
      cur.irq_n <= 1'b1;
    end
    else
      cur <= next_st;
  end

  // ----------------------------------------------------------------------
  // Pin steering and clock configuration
  // ----------------------------------------------------------------------
  // Shared pin functions selected for all ports together.
  always_comb
  begin
    logic [ports-1:0] loss;
    loss = pick(cur.control_two[bit_loss_source], framer_loss, liu_loss);
    pins.frame_alarm_pin = pick(cur.control_one[bit_frame_alarm_pin_select],
                                rx_loss_of_frame, tx_clock_loss);
    pins.alarm_pin       = pick(cur.framer_pin[3], loss, rx_sig_freeze);
    pins.rx_sync_pin     = pick(cur.framer_pin[2], rx_frame_sync, rx_multiframe_sync);
    pins.tx_channel_pin  = pick(cur.framer_pin[1], tx_channel_block, tx_channel_clock);
    pins.rx_channel_pin  = pick(cur.framer_pin[0], rx_channel_block, rx_channel_clock);
  end

  // Decodes reference, master and backplane clock fields.
  always_comb
  begin
    logic [3:0] ref_sel;
    ref_sel = cur.clock_control[7:4];
    clock_cfg = '0;
    if (ref_sel <= ref_port_last)
      clock_cfg.ref_port_onehot[ref_sel[1:0]] = 1'b1;
    clock_cfg.ref_from_master = (ref_sel == ref_master_1m544) || (ref_sel == ref_master_2m048);
    clock_cfg.ref_pin_oe      = clock_cfg.ref_from_master;
    clock_cfg.ref_external    = (ref_sel == ref_external);
    clock_cfg.ref_is_1m544    = cur.clock_control[3];
    clock_cfg.master_family   = cur.clock_control[2];
    clock_cfg.master_multiplier = 4'h1 << cur.clock_control[1:0];
    clock_cfg.backplane_mult  = 5'h1 << cur.framer_pin[5:4];
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign host_rdata                = cur.rdata;
  assign port_wr                   = cur.wr_pulse;
  assign port_wr_offset            = cur.wr_offset;
  assign port_wr_data              = cur.wr_data;
  assign counter_latch_pulse       = cur.latch_pulse;
  assign liu_soft_reset            = cur.liu_reset;
  assign framer_soft_reset         = cur.framer_reset;
  assign interrupt_out_n           = cur.irq_n;
  assign interleave_mode_field     = interleave_mode_t'(cur.framer_pin[7:6]);
  assign interleave_wire_or_select = cur.control_one[bit_interleave_wire_or];
  // Sync pin: driven with the internal pulse, or taken from the system.
  assign tx_system_sync_pin_oe     = cur.control_two[bit_sync_pin_direction];
  assign tx_system_sync_pin_out    = frame_pulse_8k;
  assign tx_sync_to_framers        = tx_system_sync_pin_oe ? frame_pulse_8k
                                                           : tx_system_sync_pin_in;

endmodule // quad_transceiver_global_control
